// ===== ee2w_pkg.sv
// constants for the two-wire serial memory host: register map, fields, timing, bus codes
// assumes a 100 MHz pclk and an apb master with 32-bit data
package ee2w_pkg;

   // apb address width and register byte offsets
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] OFF_CFG     = 12'h000;  // straps and write protect
   localparam logic [11:0] OFF_CMD     = 12'h004;  // launches a bus sequence
   localparam logic [11:0] OFF_TXDATA  = 12'h008;  // byte to send
   localparam logic [11:0] OFF_RXDATA  = 12'h00C;  // last byte shifted in
   localparam logic [11:0] OFF_STATUS  = 12'h010;  // engine state and sticky flags

   // cfg fields
   localparam int CFG_STRAP_LOW  = 0;
   localparam int CFG_STRAP_HIGH = 1;
   localparam int CFG_WP         = 2;
   localparam logic [2:0] CFG_RESET = 3'h0;

   // cmd fields
   localparam int CMD_START = 0;  // start or repeated start first
   localparam int CMD_BYTE  = 1;  // one byte plus its acknowledge slot
   localparam int CMD_STOP  = 2;  // stop last
   localparam int CMD_RX    = 3;  // byte is received, not sent
   localparam int CMD_MACK  = 4;  // master acknowledges a received byte
   localparam int CMD_CTRL  = 5;  // send a composed control byte instead of txdata
   localparam int CMD_RW    = 6;  // direction bit of the composed control byte
   localparam int CMD_BLOCK = 7;  // block select bit of the composed control byte

   // status fields
   localparam int ST_BUSY    = 0;
   localparam int ST_ACK     = 1;
   localparam int ST_DONE    = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_INXFER  = 4;

   // control byte layout
   localparam logic [3:0] CTRL_CODE = 4'hA;  // device code 1010
   localparam logic       RW_READ   = 1'b1;
   localparam logic       RW_WRITE  = 1'b0;
   localparam logic [3:0] ACK_BIT   = 4'h8;  // ninth bit of every byte

   // timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SCL_PERIOD_NS   = 10000;  // 100 kHz bus clock
   localparam int QTR_CYCLES_DFLT = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   // engine states
   typedef enum logic [1:0] {
      EE_IDLE,
      EE_START,
      EE_BITS,
      EE_STOP
   } ee2w_state_t;

endpackage

// ===== ee2w_host.sv
// two-wire bus master for a serial memory, with an apb register slave for software
// assumes sda is open drain with an external pull-up and the memory only listens to scl
//
// Operation
// - fixed select strap held high always
// - chip-select straps defined before any transaction
// - master makes scl, start and stop
// - start only while sda and scl high
// - sda falling, scl high, is start
// - sda rising, scl high, is stop
// - one bit per pulse, change while low
// - master picks the number of bytes
// - receiver acknowledges each byte, extra pulse
// - master ends reads with no acknowledge
// - address high byte first, then low
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps

module ee2w_host #(
   parameter int QTR_CYCLES = ee2w_pkg::QTR_CYCLES_DFLT   // pclk cycles per quarter scl period
) (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ee2w_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic                             scl_o,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe,
   output logic                             chip_sel_strap_low,
   output logic                             chip_sel_strap_high,
   output logic                             fixed_select_strap,
   output logic                             write_protect
);
   import ee2w_pkg::*;

   localparam int QW = (QTR_CYCLES > 1) ? $clog2(QTR_CYCLES) : 1;

   // the sda sampler needs two cycles of synchroniser latency inside a quarter
   if (QTR_CYCLES < 4) begin : g_bad_div
      $error("QTR_CYCLES must be at least 4");
   end

   ee2w_state_t     state_q;      // engine state
   logic [1:0]      phase_q;      // quarter of the current scl period
   logic [3:0]      bit_q;        // bit index, 8 is the acknowledge slot
   logic [QW-1:0]   qcnt_q;       // quarter divider
   logic [7:0]      sh_q;         // shift register, msb leaves first
   logic [7:0]      rxdata_q;     // last received byte
   logic [7:0]      txdata_q;     // byte software wants sent
   logic [2:0]      cfg_q;        // straps and write protect
   logic            pend_byte_q;  // a byte follows the start
   logic            pend_stop_q;  // a stop closes the sequence
   logic            rx_q;         // current byte is received
   logic            mack_q;       // master acknowledges the received byte
   logic            in_xfer_q;    // between our start and our stop
   logic            ack_seen_q;   // slave pulled the acknowledge slot low
   logic            done_q;       // sticky: a sequence finished
   logic            refused_q;    // sticky: a command was refused
   logic            scl_q;        // scl driven level
   logic            sda_low_q;    // pulling sda low
   logic            sda_m_q;      // synchroniser first stage
   logic            sda_s_q;      // synchronised sda
   logic [31:0]     prdata_q;     // read data captured in setup
   logic [15:0]     hi_cnt_q;     // helper: cycles of scl high, saturating

   logic busy;
   logic tick;
   logic fin;
   logic acc_wr;
   logic wr_cmd;
   logic cmd_any;
   logic refuse;
   logic go;
   logic cfg_lock;
   logic unmapped;
   logic [7:0] ctrl_byte;

   // apb answers at once; read data was captured in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_q;

   // open-drain data pin: never driven high, released for a one
   assign sda_o  = 1'b0;
   assign sda_oe = sda_low_q;
   assign scl_o  = scl_q;   // we alone make the bus clock

   // straps and write protect come straight from cfg flops
   assign chip_sel_strap_low  = cfg_q[CFG_STRAP_LOW];
   assign chip_sel_strap_high = cfg_q[CFG_STRAP_HIGH];
   assign write_protect       = cfg_q[CFG_WP];   // high makes the memory drop writes
   assign fixed_select_strap  = 1'b1;            // the memory is dead without it

   assign busy = (state_q != EE_IDLE);
   assign tick = busy && (qcnt_q == QW'(QTR_CYCLES - 1));

   // last quarter of the last step of a sequence
   assign fin = tick && (phase_q == 2'h3) &&
                (((state_q == EE_START) && !pend_byte_q && !pend_stop_q) ||
                 ((state_q == EE_BITS) && (bit_q == ACK_BIT) && !pend_stop_q) ||
                 (state_q == EE_STOP));

   // control byte from our own straps, so the select bits always match
   assign ctrl_byte = {CTRL_CODE, pwdata[CMD_BLOCK], cfg_q[CFG_STRAP_HIGH],
                       cfg_q[CFG_STRAP_LOW], pwdata[CMD_RW]};

   // apb decode
   assign acc_wr   = psel && penable && pwrite;
   assign cfg_lock = busy || in_xfer_q;   // straps and wp frozen during a transfer
   assign unmapped = (paddr != OFF_CFG) && (paddr != OFF_CMD) && (paddr != OFF_TXDATA) &&
                     (paddr != OFF_RXDATA) && (paddr != OFF_STATUS);
   assign wr_cmd   = acc_wr && (paddr == OFF_CMD) && !busy;
   assign cmd_any  = pwdata[CMD_START] || pwdata[CMD_BYTE] || pwdata[CMD_STOP];

   // a fresh start needs an idle bus; a byte or stop outside a transfer has no start
   assign refuse = (pwdata[CMD_START] && !in_xfer_q && !(sda_s_q && scl_q)) ||
                   (!pwdata[CMD_START] && !in_xfer_q);
   assign go     = wr_cmd && cmd_any && !refuse;

   // error answer: unknown address, command while busy, cfg while locked
   assign pslverr = psel && penable &&
                    (unmapped ||
                     (pwrite && (paddr == OFF_CMD) && busy) ||
                     (pwrite && (paddr == OFF_CFG) && cfg_lock));

   // sda synchroniser, second stage alone is read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_m_q <= 1'b1;
         sda_s_q <= 1'b1;
      end else begin
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end
   end

   // quarter divider, parked at zero while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qcnt_q <= '0;
      end else if (!busy || tick) begin
         qcnt_q <= '0;
      end else begin
         qcnt_q <= qcnt_q + QW'(1);
      end
   end

   // sequence engine: start, bits, stop; software picks the byte count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= EE_IDLE;
         phase_q     <= 2'h0;
         bit_q       <= 4'h0;
         sh_q        <= 8'h00;
         rxdata_q    <= 8'h00;
         pend_byte_q <= 1'b0;
         pend_stop_q <= 1'b0;
         rx_q        <= 1'b0;
         mack_q      <= 1'b0;
         in_xfer_q   <= 1'b0;
         ack_seen_q  <= 1'b0;
      end else if (go) begin
         // launch; a start inside a transfer is a repeated start
         phase_q     <= 2'h0;
         bit_q       <= 4'h0;
         pend_byte_q <= pwdata[CMD_BYTE];
         pend_stop_q <= pwdata[CMD_STOP];
         rx_q        <= pwdata[CMD_RX];
         mack_q      <= pwdata[CMD_MACK];
         sh_q        <= pwdata[CMD_RX] ? 8'hFF : (pwdata[CMD_CTRL] ? ctrl_byte : txdata_q);
         if (pwdata[CMD_START]) begin
            state_q <= EE_START;
         end else if (pwdata[CMD_BYTE]) begin
            state_q <= EE_BITS;
         end else begin
            state_q <= EE_STOP;
         end
      end else if (tick) begin
         phase_q <= phase_q + 2'h1;
         unique case (state_q)
            EE_IDLE: begin
               // not reached: tick needs busy
            end
            EE_START: begin
               if (phase_q == 2'h3) begin
                  in_xfer_q <= 1'b1;
                  if (pend_byte_q) begin
                     state_q <= EE_BITS;
                  end else if (pend_stop_q) begin
                     state_q <= EE_STOP;
                  end else begin
                     state_q <= EE_IDLE;
                  end
               end
            end
            EE_BITS: begin
               // sample in the middle of the high phase
               if (phase_q == 2'h2) begin
                  if (bit_q == ACK_BIT) begin
                     ack_seen_q <= !sda_s_q;   // low means acknowledged; polling reads this
                  end else begin
                     sh_q <= {sh_q[6:0], sda_s_q};
                  end
               end
               if (phase_q == 2'h3) begin
                  if (bit_q == ACK_BIT) begin
                     bit_q       <= 4'h0;
                     pend_byte_q <= 1'b0;
                     rxdata_q    <= sh_q;
                     state_q     <= pend_stop_q ? EE_STOP : EE_IDLE;
                  end else begin
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end
            EE_STOP: begin
               if (phase_q == 2'h3) begin
                  in_xfer_q <= 1'b0;
                  state_q   <= EE_IDLE;
               end
            end
         endcase
      end
   end

   // pin levels per quarter; sda only moves with scl low except in start and stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q     <= 1'b1;   // bus released at reset
         sda_low_q <= 1'b0;
      end else if (tick) begin
         unique case (phase_q)
            2'h0: begin
               if (state_q == EE_START) begin
                  sda_low_q <= 1'b0;                    // release before a repeated start
               end else if (state_q == EE_STOP) begin
                  sda_low_q <= 1'b1;                    // low before the stop edge
               end else if (bit_q != ACK_BIT) begin
                  sda_low_q <= !rx_q && !sh_q[7];       // data bit, released when receiving
               end else begin
                  sda_low_q <= rx_q && mack_q;          // ack a read byte when mack_q is set, else release (nack)
               end
            end
            2'h1: begin
               scl_q <= 1'b1;
            end
            2'h2: begin
               if (state_q == EE_START) begin
                  sda_low_q <= 1'b1;                    // start: fall with scl high
               end else if (state_q == EE_STOP) begin
                  sda_low_q <= 1'b0;                    // stop: rise with scl high
               end
            end
            2'h3: begin
               if (state_q != EE_STOP) begin
                  scl_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // software registers; an address is sent high byte first by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q    <= CFG_RESET;   // straps defined from reset onward
         txdata_q <= 8'h00;
      end else if (acc_wr) begin
         if ((paddr == OFF_CFG) && !cfg_lock) begin
            cfg_q <= pwdata[2:0];
         end
         if (paddr == OFF_TXDATA) begin
            txdata_q <= pwdata[7:0];
         end
      end
   end

   // sticky flags, write one to clear; a set in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (fin) begin
            done_q <= 1'b1;
         end else if (acc_wr && (paddr == OFF_STATUS) && pwdata[ST_DONE]) begin
            done_q <= 1'b0;
         end
         if (wr_cmd && cmd_any && refuse) begin
            refused_q <= 1'b1;
         end else if (acc_wr && (paddr == OFF_STATUS) && pwdata[ST_REFUSED]) begin
            refused_q <= 1'b0;
         end
      end
   end

   // read data captured in the setup cycle so it is a flop in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            OFF_CFG:    prdata_q <= {29'h0, cfg_q};
            OFF_TXDATA: prdata_q <= {24'h0, txdata_q};
            OFF_RXDATA: prdata_q <= {24'h0, rxdata_q};
            OFF_STATUS: prdata_q <= {27'h0, in_xfer_q, refused_q, done_q, ack_seen_q, busy};
            default:    prdata_q <= 32'h0000_0000;   // cmd and unmapped read zero
         endcase
      end
   end

   // helper for the assertions: length of each scl high phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt_q <= 16'h0000;
      end else if (!scl_q) begin
         hi_cnt_q <= 16'h0000;
      end else if (hi_cnt_q != 16'hFFFF) begin
         hi_cnt_q <= hi_cnt_q + 16'h0001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sda_stable_a: assert property (scl_q && $changed(sda_low_q) |->
      ($past(state_q) == EE_START) || ($past(state_q) == EE_STOP))
      else $error("sda moved with scl high outside start or stop");

   start_edge_a: assert property ($rose(sda_low_q) && scl_q |->
      ($past(state_q) == EE_START) && ($past(phase_q) == 2'h2))
      else $error("sda fell under high scl outside a start");

   stop_edge_a: assert property ($fell(sda_low_q) && scl_q && $past(scl_q) |->
      ($past(state_q) == EE_STOP) || ($past(state_q) == EE_START))
      else $error("sda rose under high scl outside stop or repeated start");

   idle_start_a: assert property (go && pwdata[CMD_START] && !in_xfer_q |->
      sda_s_q && scl_q ##1 scl_q && !sda_low_q)
      else $error("start launched on a busy bus");

   scl_high_a: assert property ($fell(scl_q) |->
      $past(hi_cnt_q) >= 16'(2 * QTR_CYCLES - 1))
      else $error("scl high phase too short");

   read_nack_a: assert property ((state_q == EE_BITS) && (bit_q == ACK_BIT) &&
      rx_q && !mack_q && scl_q |-> !sda_low_q)
      else $error("last read byte was acknowledged");

   read_ack_a: assert property ((state_q == EE_BITS) && (bit_q == ACK_BIT) &&
      rx_q && mack_q && scl_q |-> sda_low_q)
      else $error("read byte not acknowledged");

   strap_frozen_a: assert property (in_xfer_q && $past(in_xfer_q) |->
      $stable(cfg_q))
      else $error("strap or write protect changed inside a transfer");

   fixed_strap_a: assert property (fixed_select_strap && !sda_o)
      else $error("fixed strap low or sda driven high");

   ctrl_code_a: assert property (go && pwdata[CMD_CTRL] && !pwdata[CMD_RX] |=>
      (sh_q[7:4] == CTRL_CODE) && (sh_q[2:1] == cfg_q[1:0]))
      else $error("control byte composed wrongly");

   seq_end_a: assert property (fin |=> !busy ##1 done_q)
      else $error("sequence end not reported");

   start_cov: cover property (go && pwdata[CMD_START] && pwdata[CMD_BYTE] && pwdata[CMD_CTRL]);
   rstart_cov: cover property (go && pwdata[CMD_START] && in_xfer_q);
   ack_cov: cover property ((state_q == EE_BITS) && (bit_q == ACK_BIT) && (phase_q == 2'h3) && ack_seen_q);
   stop_cov: cover property ((state_q == EE_STOP) && fin);
   refuse_cov: cover property (wr_cmd && cmd_any && refuse);

endmodule // ee2w_host

// ===== ee2w_mem_model.sv
// behavioural two-wire serial memory answering the host on scl and sda
// assumes the bench resolves sda with a pull-up and the host drives scl
`timescale 1ns/1ps

module ee2w_mem_model #(
   parameter int TWC_NS = 2500  // programming time, kept short
) (
   input  wire logic scl,       // listened to only, slave side
   input  wire logic sda,
   input  wire logic strap_low,
   input  wire logic strap_high,
   input  wire logic fixed_strap,
   input  wire logic wp,
   output logic      sda_pull   // pull low only, never high
);
   logic [7:0]  mem [int];            // sparse array, unwritten reads FF
   logic [7:0]  sh, cur, wctrl, dat;  // shifter, control, busy tag, out byte
   logic [16:0] ptr, wptr;            // bit 16 picks the half
   logic [7:0]  pend [$];             // page buffer, any length
   int          cnt, nb = -1;         // bit and byte count, -1 ignores the bus
   bit          sel, tx, tend;        // addressed, sending, read ended
   realtime     busy_t = 0;           // end of programming
   initial sda_pull = 1'b0;           // released from power-up
   // start abandons any byte in flight
   always @(negedge sda) if (scl === 1'b1) begin
      cnt = 0;
      nb = 0;
      {sel, tx, tend, sda_pull} = 4'h0;
      pend.delete();
   end
   // stop commits the page unless protected
   always @(posedge sda) if (scl === 1'b1) begin
      if (sel && !cur[0] && pend.size() > 0 && !wp) begin
         foreach (pend[i]) mem[wptr + i] = pend[i];
         wctrl = cur;
         busy_t = $realtime + TWC_NS;
      end
      nb = -1;
      sda_pull = 1'b0;
   end
   // bits are taken while scl is high
   always @(posedge scl) if (nb >= 0) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (tx && sda) tend = 1'b1;  // no acknowledge ends the read
      cnt++;
   end
   // sda only changes while scl is low
   always @(negedge scl) if (nb >= 0) begin
      if (cnt == 8 && !tx) begin
         if (nb == 0) begin  // control byte
            cur = sh;
            sel = sh[7:4] == 4'hA && sh[2:1] == {strap_high, strap_low} && fixed_strap
                  && !($realtime < busy_t && sh == wctrl);
            ptr[16] = sh[3];    // block half
            tx = sel && sh[0];  // one reads, zero writes
         end
         else if (nb == 1) ptr[15:8] = sh;  // high byte first
         else if (nb == 2) begin
            ptr[7:0] = sh;
            wptr = ptr;
         end
         else pend.push_back(sh);
         sda_pull = sel;  // ack held over the high phase
         nb++;
      end
      else if (cnt == 8) sda_pull = 1'b0;  // master's acknowledge slot
      else if (cnt >= 9) begin
         cnt = 0;
         sda_pull = 1'b0;
         if (tx && !tend) begin  // count wraps inside its half
            dat = mem.exists(ptr) ? mem[ptr] : 8'hFF;
            ptr[15:0] = ptr[15:0] + 16'h1;
            sda_pull = !dat[7];
         end
      end
      else if (tx && !tend) sda_pull = !dat[7 - cnt];
   end
endmodule  // ee2w_mem_model

// ===== tb_ee2w_host.sv
// self-checking bench: apb stimulus into the two-wire host, memory model on its bus
// assumes ee2w_pkg, ee2w_host and ee2w_mem_model are compiled first
`timescale 1ns/1ps

module tb_ee2w_host;
   import ee2w_pkg::*;
   localparam logic [31:0] C_ST = 32'h1 << CMD_START, C_BY = 32'h1 << CMD_BYTE, C_SP = 32'h1 << CMD_STOP;
   localparam logic [31:0] C_RX = 32'h1 << CMD_RX, C_MK = 32'h1 << CMD_MACK, C_CT = 32'h1 << CMD_CTRL;
   localparam logic [31:0] C_RW = 32'h1 << CMD_RW;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;  // apb side
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, st, rng;  // last read, last status, xorshift state
   logic        scl, sda_o, sda_oe, pull, sda_w, s_lo, s_hi, s_fix, wp;  // bus and straps
   logic [33:0] exp_q [$], ev;  // notes {check data, error, data}
   logic [15:0] a;              // word address
   logic [7:0]  d, b;           // data and raw control byte
   int          err_count = 0, samples_checked = 0;
   assign sda_w = !((sda_oe && !sda_o) || pull);  // open drain with pull-up
   ee2w_host #(.QTR_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_o(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .chip_sel_strap_low(s_lo),
      .chip_sel_strap_high(s_hi), .fixed_select_strap(s_fix), .write_protect(wp));
   ee2w_mem_model mem (.scl(scl), .sda(sda_w), .strap_low(s_lo), .strap_high(s_hi), .fixed_strap(s_fix),
      .wp(wp), .sda_pull(pull));
   initial begin  // 100 MHz
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] x);  // xorshift step
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic final_report;
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic hang;  // a bounded wait ran out
      err_count++;
      final_report;
   endtask
   // one apb transfer; its note is queued first, the monitor judges it
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] v, input logic [33:0] e);
      int n;
      exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] ad, input logic [31:0] v, input logic e);
      apb(1'b1, ad, v, {1'b0, e, 32'h0});
   endtask
   task automatic rd(input logic [11:0] ad, input logic [31:0] v);
      apb(1'b0, ad, 32'h0, {2'b10, v});
   endtask
   // launch a bus sequence, poll busy, keep the status, clear done and refused
   task automatic cmd(input logic [31:0] c);
      int n;
      wr(OFF_CMD, c, 1'b0);
      n = 0;
      do begin
         apb(1'b0, OFF_STATUS, 32'h0, 34'h0);
         n++;
      end while (rv[ST_BUSY] !== 1'b0 && n < 200);
      if (n >= 200) hang();
      st = rv;
      check("done", 32'(st[ST_DONE]), 32'h1);
      wr(OFF_STATUS, 32'hC, 1'b0);
   endtask
   task automatic txb(input logic [7:0] v, input logic [31:0] c);  // one byte out
      wr(OFF_TXDATA, {24'h0, v}, 1'b0);
      cmd(c | C_BY);
      check("byte ack", 32'(st[ST_ACK]), 32'h1);
   endtask
   task automatic mem_write(input logic bk, input logic [7:0] v);  // two-byte page write
      cmd(C_ST | C_BY | C_CT | (32'(bk) << CMD_BLOCK));
      check("ctrl ack", 32'(st[ST_ACK]), 32'h1);
      txb(a[15:8], 32'h0);  // high address byte first
      txb(a[7:0], 32'h0);
      txb(v, 32'h0);
      txb(v + 8'h1, C_SP);  // byte count chosen here
   endtask
   task automatic mem_read(input logic bk, input logic [7:0] v);  // random read of two bytes
      cmd(C_ST | C_BY | C_CT | (32'(bk) << CMD_BLOCK));
      txb(a[15:8], 32'h0);
      txb(a[7:0], 32'h0);
      cmd(C_ST | C_BY | C_CT | C_RW | (32'(bk) << CMD_BLOCK));  // repeated start
      check("rd ack", 32'(st[ST_ACK]), 32'h1);
      cmd(C_BY | C_RX | C_MK);
      rd(OFF_RXDATA, {24'h0, v});
      cmd(C_BY | C_RX | C_SP);  // last byte left unacknowledged
      rd(OFF_RXDATA, {24'h0, v + 8'h1});
   endtask
   task automatic poll(input logic bk);  // resend the control byte until acknowledged
      int n;
      n = 0;
      do begin
         cmd(C_ST | C_BY | C_SP | C_CT | (32'(bk) << CMD_BLOCK));
         n++;
      end while (st[ST_ACK] !== 1'b1 && n < 20);
      if (n >= 20) hang();
   endtask
   always @(posedge pclk) if (psel && penable && pready === 1'b1) begin  // judge each finished transfer
      ev = exp_q.pop_front();
      check("pslverr", 32'(pslverr), 32'(ev[32]));
      if (ev[33]) check("prdata", prdata, ev[31:0]);
   end
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rng = 32'h39;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check("idle sda", 32'(sda_w), 32'h1);
      check("idle scl", 32'(scl), 32'h1);
      rd(OFF_CFG, 32'(CFG_RESET));
      rd(OFF_STATUS, 32'h0);
      apb(1'b0, 12'h014, 32'h0, {2'b11, 32'h0});  // unmapped place errs
      wr(OFF_CMD, C_BY, 1'b0);  // byte with no open transfer
      apb(1'b0, OFF_STATUS, 32'h0, 34'h0);
      check("refused", 32'(rv[ST_REFUSED]), 32'h1);
      wr(OFF_STATUS, 32'hC, 1'b0);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_CFG, 32'(k), 1'b0);
         @(negedge pclk);  // strap flops settle after the access edge
         check("straps", {30'h0, s_hi, s_lo}, 32'(k));
         check("fixed strap", 32'(s_fix), 32'h1);
         for (int j = 0; j < 5; j++) begin
            b = {CTRL_CODE ^ 4'(j / 4), 1'b0, 2'(k) ^ 2'(j), 1'b0};
            wr(OFF_TXDATA, {24'h0, b}, 1'b0);
            cmd(C_ST | C_BY | C_SP);
            check("select ack", 32'(st[ST_ACK]), 32'(j == 0));
         end
      end
      cmd(C_ST | C_BY | C_CT);  // transfer left open
      wr(OFF_CFG, 32'h0, 1'b1);  // straps locked inside a transfer
      cmd(C_SP);
      for (int n = 0; n < 2; n++) begin
         rng = nxt(rng);
         wr(OFF_CFG, {30'h0, rng[17:16]}, 1'b0);
         a = rng[15:0] & 16'hFFF0;
         d = rng[31:24];
         mem_write(1'b0, d);
         cmd(C_ST | C_BY | C_SP | C_CT);
         check("busy nack", 32'(st[ST_ACK]), 32'h0);
         poll(1'b0);
         mem_write(1'b1, ~d);
         poll(1'b1);
         mem_read(1'b0, d);
         mem_read(1'b1, ~d);
         wr(OFF_CFG, {30'h1, rng[17:16]}, 1'b0);
         mem_write(1'b0, d ^ 8'h5A);
         cmd(C_ST | C_BY | C_SP | C_CT);
         check("no cycle", 32'(st[ST_ACK]), 32'h1);
         mem_read(1'b0, d);
      end
      final_report;
   end
endmodule  // tb_ee2w_host
